// *** dv/bpsh_host.sv ***
`timescale 1ns/10ps
module bpsh_host (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o = 1'b0,
  output logic wb_stb_o = 1'b0,
  output logic wb_we_o = 1'b0,
  output logic [7:0] wb_adr_o = 8'h00,
  output logic [3:0] wb_sel_o = 4'h0,
  output logic [31:0] wb_dat_o = 32'h00000000
);
  // One classic cycle; request held until ack, then one idle cycle
  // Software programs the bus number through this path
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
    input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= dat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~adr; // Released address and data lines do not keep the last value; select does
    wb_dat_o <= ~dat;
    @(posedge clk_i);
  endtask
endmodule

// *** dv/bridge_primary_status_header_tb.sv ***
`timescale 1ns/10ps
`include "bpsh_defs.svh"
module bridge_primary_status_header_tb;
  import bpsh_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [15:0] cmd = 16'h0000;
  logic [5:0] ev = 6'h00;
  logic cyc, stb, we, ack;
  logic [7:0] adr, pbn;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int n_fail = 0;
  int n_tests = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, master model and design
  initial forever #4 clk = ~clk;
  bpsh_host host (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  bpsh_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .cmd_word_i(cmd),
    .parity_err_i(ev[0]), .cpl_abort_sent_i(ev[1]), .rx_cpl_abort_i(ev[2]),
    .rx_cpl_ur_i(ev[3]), .err_msg_sent_i(ev[4]), .poisoned_rx_i(ev[5]),
    .wb_ack_o(ack), .wb_dat_o(rdat), .primary_bus_number_o(pbn));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(1'b0, a, 4'hF, 32'h00000000, d);
    check(what, d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, s, d, r);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rchk("status", 8'h04, 32'h00100000);
    rchk("class", 8'h08, {8'h06, 8'h04, 8'h00, `BPSH_REVISION});
    rchk("hdr", 8'h0C, 32'h00010000);
    rchk("bus", 8'h18, 32'h00000000);
    rchk("unmapped", 8'h10, 32'h00000000);
    $display("test reset values done");
  endtask
  task automatic t_rw();
    wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    rchk("hdr", 8'h0C, 32'h000100FF);
    wr(8'h18, 4'hF, 32'hFFFFFF5A);
    wr(8'h18, 4'hE, 32'h00000033);
    wr(8'h08, 4'hF, 32'h00000000);
    rchk("bus", 8'h18, 32'h0000005A);
    check("bus_out", {24'h0, pbn}, 32'h0000005A);
    rchk("class", 8'h08, {8'h06, 8'h04, 8'h00, `BPSH_REVISION});
    $display("test read write done");
  endtask
  task automatic t_events();
    pulse(6'h3F);
    rchk("gated", 8'h04, 32'hB8100000);
    wr(8'h04, 4'hF, 32'h00000000);
    wr(8'h04, 4'h7, 32'hFFFFFFFF);
    rchk("kept", 8'h04, 32'hB8100000);
    wr(8'h04, 4'h8, 32'h80000000);
    rchk("clr31", 8'h04, 32'h38100000);
    cmd <= 16'h0140;
    pulse(6'h11);
    rchk("enabled", 8'h04, 32'h79100140);
    wr(8'h04, 4'h8, 32'hC1000000);
    rchk("clr", 8'h04, 32'h38100140);
    // Poisoned packet in the very cycle the clear is taken
    fork
      wr(8'h04, 4'h8, 32'h80000000);
      begin
        @(posedge clk);
        ev <= 6'h20;
        @(posedge clk);
        ev <= 6'h00;
      end
    join
    rchk("set_wins", 8'h04, 32'hB8100140);
    $display("test events done");
  endtask
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pulse(6'h3F);
    ce <= 1'b1;
    rchk("frozen", 8'h04, 32'h00100000);
    $display("test clock enable done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, second reset in mid-run, and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_events();
    @(posedge clk);
    rst <= 1'b1;
    cmd <= 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_freeze();
    finish_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule

// *** hw/bpsh_defs.svh ***
// Operation
// RULE_01: Pending legacy interrupt bit 19 reads zero
// RULE_02: Capability list bit 20 reads one
// RULE_03: Bits 21, 23, 26:25 hardwired zero
// RULE_04: Bit 24 sets on primary parity error
// RULE_05: Bit 24 never sets without parity enable
// RULE_06: Bit 27 sets on sent completer abort
// RULE_07: Bit 28 sets on received completer abort
// RULE_08: Bit 29 sets on received unsupported request
// RULE_09: Bit 30 sets on error message, enabled
// RULE_10: Bit 31 sets on received poisoned packet
// RULE_11: Revision byte is hardwired read-only code
// RULE_12: Class bytes read 06h and 04h
// RULE_13: Programming interface byte reads 00h
// RULE_14: Cache line size RW, reset 00h, inert
// RULE_15: Primary latency timer reads constant 00h
// RULE_16: Header type byte reads 01h
// RULE_17: Primary bus number RW, reset 00h
// RULE_18: Parity response enable is command bit 6
// RULE_19: Error report enable is command bit 8
// RULE_20: Write one clears, zero keeps, reserved zero; bits 27 to 29 ignore writes and hold until reset
`ifndef BPSH_DEFS_SVH
`define BPSH_DEFS_SVH
// Word offsets (byte addresses)
`define BPSH_OFS_STATUS 8'h04
`define BPSH_OFS_CLASS 8'h08
`define BPSH_OFS_HDR 8'h0C
`define BPSH_OFS_BUS 8'h18
// Status bit positions in the 32-bit word
`define BPSH_BIT_INTX 19
`define BPSH_BIT_CAP 20
`define BPSH_BIT_MDPE 24
`define BPSH_BIT_STA 27
`define BPSH_BIT_RTA 28
`define BPSH_BIT_RMA 29
`define BPSH_BIT_SSE 30
`define BPSH_BIT_DPE 31
// Command bit positions
`define BPSH_CMD_PERR_EN 6
`define BPSH_CMD_ERR_EN 8
// Hardwired and reset values
// Revision code: arbitrary value, not a real part revision
`define BPSH_REVISION 8'h3A
`define BPSH_BASE_CLASS 8'h06
`define BPSH_SUB_CLASS 8'h04
`define BPSH_PROG_IF 8'h00
`define BPSH_LAT_TIMER 8'h00
`define BPSH_HDR_TYPE 8'h01
`define BPSH_CLS_RST 8'h00
`define BPSH_PBN_RST 8'h00
`endif

// *** hw/bpsh_pkg.sv ***
package bpsh_pkg;
  // Decoded register word
  typedef enum logic [2:0] {
    BPSH_SEL_NONE,
    BPSH_SEL_STATUS,
    BPSH_SEL_CLASS,
    BPSH_SEL_HDR,
    BPSH_SEL_BUS
  } bpsh_sel_t;
endpackage

// *** hw/bpsh_top.sv ***
`timescale 1ns/10ps
`include "bpsh_defs.svh"
module bpsh_top
  import bpsh_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic parity_err_i,
  input wire logic cpl_abort_sent_i,
  input wire logic rx_cpl_abort_i,
  input wire logic rx_cpl_ur_i,
  input wire logic err_msg_sent_i,
  input wire logic poisoned_rx_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic [7:0] primary_bus_number_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic mdpe;
  logic sta;
  logic rta;
  logic rma;
  logic sse;
  logic dpe;
  logic [7:0] cache_line_size;
  logic bus_req;
  logic wr_req;
  bpsh_sel_t dec_sel;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic clr_mdpe;
  logic clr_sse;
  logic clr_dpe;
  logic perr_en;
  logic err_en;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // New request only while no ack is pending
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = bus_req && wb_we_i;

  // Command enables taken from the command word
  assign perr_en = cmd_word_i[`BPSH_CMD_PERR_EN]; // see RULE_18
  assign err_en = cmd_word_i[`BPSH_CMD_ERR_EN]; // see RULE_19

  // Word select from the byte address
  always_comb
  begin
    unique case (wb_adr_i)
      `BPSH_OFS_STATUS: dec_sel = BPSH_SEL_STATUS;
      `BPSH_OFS_CLASS: dec_sel = BPSH_SEL_CLASS;
      `BPSH_OFS_HDR: dec_sel = BPSH_SEL_HDR;
      `BPSH_OFS_BUS: dec_sel = BPSH_SEL_BUS;
      default: dec_sel = BPSH_SEL_NONE;
    endcase
  end

  // Clear strobes for the write-one-to-clear flags, upper byte lane only
  assign clr_mdpe = wr_req && (dec_sel == BPSH_SEL_STATUS) && wb_sel_i[3]
    && wb_dat_i[`BPSH_BIT_MDPE]; // see RULE_20
  assign clr_sse = wr_req && (dec_sel == BPSH_SEL_STATUS) && wb_sel_i[3]
    && wb_dat_i[`BPSH_BIT_SSE]; // see RULE_20
  assign clr_dpe = wr_req && (dec_sel == BPSH_SEL_STATUS) && wb_sel_i[3]
    && wb_dat_i[`BPSH_BIT_DPE]; // see RULE_20

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Parity error flag, gated by the response enable; set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mdpe <= 1'b0;
    else if (ce_i)
      mdpe <= (parity_err_i && perr_en) || (mdpe && !clr_mdpe); // see RULE_04, see RULE_05
  end

  // Completer abort signalled; read-only, held until reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sta <= 1'b0;
    else if (ce_i && cpl_abort_sent_i)
      sta <= 1'b1; // see RULE_06
  end

  // Completer abort received; read-only, held until reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rta <= 1'b0;
    else if (ce_i && rx_cpl_abort_i)
      rta <= 1'b1; // see RULE_07
  end

  // Unsupported request received; read-only, held until reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rma <= 1'b0;
    else if (ce_i && rx_cpl_ur_i)
      rma <= 1'b1; // see RULE_08
  end

  // Error message sent while reporting is enabled; set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sse <= 1'b0;
    else if (ce_i)
      sse <= (err_msg_sent_i && err_en) || (sse && !clr_sse); // see RULE_09
  end

  // Poisoned packet received; set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dpe <= 1'b0;
    else if (ce_i)
      dpe <= poisoned_rx_i || (dpe && !clr_dpe); // see RULE_10
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable bytes

  // Cache line size: stored and read back, steers nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cache_line_size <= `BPSH_CLS_RST; // see RULE_14
    else if (ce_i && wr_req && (dec_sel == BPSH_SEL_HDR) && wb_sel_i[0])
      cache_line_size <= wb_dat_i[7:0]; // see RULE_14
  end

  // Primary bus number, set by configuration software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      primary_bus_number_o <= `BPSH_PBN_RST; // see RULE_17
    else if (ce_i && wr_req && (dec_sel == BPSH_SEL_BUS) && wb_sel_i[0])
      primary_bus_number_o <= wb_dat_i[7:0]; // see RULE_17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Status word: fixed zeros, capability bit one, sticky flags
  always_comb
  begin
    status_word = 32'h0000_0000; // see RULE_03, see RULE_20
    status_word[15:0] = cmd_word_i;
    status_word[`BPSH_BIT_INTX] = 1'b0; // see RULE_01
    status_word[`BPSH_BIT_CAP] = 1'b1; // see RULE_02
    status_word[`BPSH_BIT_MDPE] = mdpe;
    status_word[`BPSH_BIT_STA] = sta;
    status_word[`BPSH_BIT_RTA] = rta;
    status_word[`BPSH_BIT_RMA] = rma;
    status_word[`BPSH_BIT_SSE] = sse;
    status_word[`BPSH_BIT_DPE] = dpe;
  end

  // Read data select; unmapped words read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (dec_sel)
      BPSH_SEL_STATUS: next_rdata = status_word;
      BPSH_SEL_CLASS:
        next_rdata = {`BPSH_BASE_CLASS, `BPSH_SUB_CLASS, `BPSH_PROG_IF,
          `BPSH_REVISION}; // see RULE_11, see RULE_12, see RULE_13
      BPSH_SEL_HDR:
        next_rdata = {8'h00, `BPSH_HDR_TYPE, `BPSH_LAT_TIMER,
          cache_line_size}; // see RULE_15, see RULE_16
      BPSH_SEL_BUS: next_rdata = {24'h00_0000, primary_bus_number_o};
      BPSH_SEL_NONE: next_rdata = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= bus_req;
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i && bus_req)
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Fixed status bits on every status read
  a_status_fixed: assert property ( // see RULE_01
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_STATUS
    |=> wb_ack_o && !wb_dat_o[19] && !wb_dat_o[21] && !wb_dat_o[23]
    && wb_dat_o[26:25] == 2'b00 && wb_dat_o[18:16] == 3'b000)
    else $error("fixed status bits wrong");

  // Capability bit reads one
  a_cap_bit: assert property ( // see RULE_02
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_STATUS |=> wb_dat_o[20])
    else $error("capability bit not one");

  // Parity error flag follows an enabled parity error
  a_mdpe_set: assert property ( // see RULE_04
    ce_i && parity_err_i && cmd_word_i[6] |=> mdpe)
    else $error("parity flag not set");

  // Parity flag never rises while response is disabled
  a_mdpe_gate: assert property ( // see RULE_05
    ce_i && !cmd_word_i[6] && !mdpe |=> !mdpe)
    else $error("parity flag set while disabled");

  // Abort flags set on their events and stay; unsupported flag rises only on its event
  a_abort_flags: assert property ( // see RULE_06
    ce_i && cpl_abort_sent_i |=> sta [*3])
    else $error("sent abort flag not held");

  a_rx_abort: assert property ( // see RULE_07
    ce_i && rx_cpl_abort_i |=> rta ##1 rta)
    else $error("received abort flag not held");

  a_rx_ur: assert property ( // see RULE_08
    $rose(rma) |-> $past(rx_cpl_ur_i) && $past(ce_i))
    else $error("unsupported flag rose without cause");

  // Error message flag needs reporting enabled
  a_sse_gate: assert property ( // see RULE_09
    $rose(sse) |-> $past(err_msg_sent_i) && $past(cmd_word_i[8]))
    else $error("error message flag rose without cause");

  // Poisoned packet wins over a same-cycle clear
  a_dpe_set: assert property ( // see RULE_10
    ce_i && poisoned_rx_i && clr_dpe |=> dpe)
    else $error("poisoned flag lost to clear");

  // Identity bytes on a class word read
  a_class_word: assert property ( // see RULE_12
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_CLASS
    |=> wb_dat_o[31:16] == 16'h0604 && wb_dat_o[15:8] == 8'h00
    && wb_dat_o[7:0] == `BPSH_REVISION)
    else $error("class word wrong");

  // Header word fixed bytes
  a_hdr_word: assert property ( // see RULE_16
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_HDR
    |=> wb_dat_o[31:8] == 24'h00_0100)
    else $error("header word wrong");

  // Write of a one clears, write of a zero keeps
  a_w1c_clear: assert property ( // see RULE_20
    ce_i && clr_sse && !err_msg_sent_i |=> !sse)
    else $error("write one did not clear");

  a_w0_keep: assert property ( // see RULE_20
    ce_i && wr_req && dec_sel == BPSH_SEL_STATUS && !wb_dat_i[31] && dpe |=> dpe)
    else $error("write zero cleared a flag");

  // Bus number write lands on the next edge
  a_bus_write: assert property ( // see RULE_17
    ce_i && wr_req && dec_sel == BPSH_SEL_BUS && wb_sel_i[0]
    |=> primary_bus_number_o == $past(wb_dat_i[7:0]))
    else $error("bus number not written");

  // Cache line size write is stored
  a_cls_write: assert property ( // see RULE_14
    ce_i && wr_req && dec_sel == BPSH_SEL_HDR && wb_sel_i[0]
    |=> cache_line_size == $past(wb_dat_i[7:0]))
    else $error("cache line size not written");

  // Ack lasts one cycle only
  a_ack_pulse: assert property (
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Every taken request is answered on the next edge
  a_ack_answer: assert property (
    ce_i && bus_req |=> wb_ack_o)
    else $error("request not acknowledged");

  // Write acks return zero data
  a_wr_data_zero: assert property (
    ce_i && wr_req |=> wb_dat_o == 32'h0000_0000)
    else $error("write ack data not zero");

  // Clock enable low freezes every flag
  a_freeze_flags: assert property (
    !ce_i |=> $stable({dpe, sse, rma, rta, sta, mdpe}))
    else $error("flag moved while frozen");

  // Clock enable low freezes bus outputs and writable bytes
  a_freeze_bus: assert property (
    !ce_i
    |=> $stable({wb_ack_o, wb_dat_o, cache_line_size, primary_bus_number_o}))
    else $error("bus state moved while frozen");

  // Status read returns the flags as they stood when taken
  a_flag_read: assert property ( // see RULE_04
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_STATUS
    |=> {wb_dat_o[31:27], wb_dat_o[24]} == $past({dpe, sse, rma, rta, sta, mdpe}))
    else $error("status flags read wrong");

  // Read-only abort flags are never cleared by software
  a_sta_hold: assert property ( // see RULE_06
    sta |=> sta)
    else $error("sent abort flag dropped");

  a_rta_hold: assert property ( // see RULE_07
    rta |=> rta)
    else $error("received abort flag dropped");

  // Unsupported request completion sets its flag
  a_rma_set: assert property ( // see RULE_08
    ce_i && rx_cpl_ur_i |=> rma)
    else $error("unsupported flag not set");

  // Enabled error message sets its flag
  a_sse_set: assert property ( // see RULE_09
    ce_i && err_msg_sent_i && cmd_word_i[`BPSH_CMD_ERR_EN] |=> sse)
    else $error("error message flag not set");

  // Error message flag stays low while reporting is off
  a_sse_off: assert property ( // see RULE_09
    ce_i && !err_en && !sse |=> !sse)
    else $error("error message flag set while disabled");

  // Poisoned flag rises only on a poisoned packet
  a_dpe_rise: assert property ( // see RULE_10
    $rose(dpe) |-> $past(poisoned_rx_i) && $past(ce_i))
    else $error("poisoned flag rose without cause");

  // Parity flag clears on a write of one
  a_mdpe_clear: assert property ( // see RULE_20
    ce_i && clr_mdpe && !parity_err_i |=> !mdpe)
    else $error("parity flag not cleared");

  // Poisoned flag clears on a write of one
  a_dpe_clear: assert property ( // see RULE_20
    ce_i && clr_dpe && !poisoned_rx_i |=> !dpe)
    else $error("poisoned flag not cleared");

  // Cache line size changes only on its own write
  a_cls_keep: assert property ( // see RULE_14
    ce_i && !(wr_req && dec_sel == BPSH_SEL_HDR && wb_sel_i[0])
    |=> $stable(cache_line_size))
    else $error("cache line size changed unasked");

  // Bus number changes only on its own write
  a_bus_keep: assert property ( // see RULE_17
    ce_i && !(wr_req && dec_sel == BPSH_SEL_BUS && wb_sel_i[0])
    |=> $stable(primary_bus_number_o))
    else $error("bus number changed unasked");

  // Bus number word reads back the stored byte
  a_bus_word: assert property ( // see RULE_17
    ce_i && bus_req && !wb_we_i && dec_sel == BPSH_SEL_BUS
    |=> wb_dat_o == {24'h00_0000, $past(primary_bus_number_o)})
    else $error("bus number word read wrong");

endmodule
